// File: tb/camera_acquisition_trigger_control_tb_top.sv
// testbench for the acquisition trigger controller
`timescale 1ns/100ps
module camera_acquisition_trigger_control_tb_top;
    localparam logic [31:0] EXPO = 32'h0000_000C;
    localparam logic [31:0] RDOUT = 32'h0000_000A;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    acq_trig_pkg::axil_req_t req = '0;
    acq_trig_pkg::axil_rsp_t rsp;
    logic cc, hw, tmr, strobe, fa;
    logic fa_q = 1'b0;
    logic [31:0] rd;
    logic [1:0] rr;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0, sw = 0, last_w = 0, frames = 0, gap = 0, rise_c = 0, f0 = 0;
    always #5 clock_i = ~clock_i;
    acq_trig_ctrl i_acq_trig_ctrl (.clock_i(clock_i), .rst_n_i(rst_n_i), .axil_req_i(req),
        .axil_rsp_o(rsp), .hw_trigger_input_i(hw), .cc_line_i(cc),
        .timer_active_signal_i(tmr), .strobe_out_o(strobe), .frame_active_o(fa));
    grabber_model i_grabber_model (.clock_i(clock_i), .cc_line_o(cc), .hw_line_o(hw),
        .timer_o(tmr));
    // strobe width, frame count and spacing of frame starts
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        fa_q <= fa;
        if (strobe === 1'b1)
            sw <= sw + 1;
        else if (sw != 0) begin
            last_w <= sw;
            sw <= 0;
        end
        if (fa === 1'b1 && fa_q !== 1'b1) begin
            frames <= frames + 1;
            gap <= cyc - rise_c;
            rise_c <= cyc;
        end
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            summarize();
        end
    end
    task automatic summarize();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // write: both channels offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_p;
        logic w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge clock_i);
            if (aw_p && rsp.awready === 1'b1) begin
                aw_p = 1'b0;
                req.awvalid <= 1'b0;
            end
            if (w_p && rsp.wready === 1'b1) begin
                w_p = 1'b0;
                req.wvalid <= 1'b0;
            end
        end while (rsp.bvalid !== 1'b1);
        rr = rsp.bresp;
        req.bready <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rdr(input logic [7:0] a);
        logic ar_p;
        ar_p = 1'b1;
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge clock_i);
            if (ar_p && rsp.arready === 1'b1) begin
                ar_p = 1'b0;
                req.arvalid <= 1'b0;
            end
        end while (rsp.rvalid !== 1'b1);
        rd = rsp.rdata;
        rr = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic cmd(input int b);
        wr(acq_trig_pkg::OFF_CMD, 32'h0000_0001 << b);
    endtask
    task automatic t_regs();
        logic [7:0] a [5] = '{acq_trig_pkg::OFF_EXPOSE, acq_trig_pkg::OFF_PERIOD,
            acq_trig_pkg::OFF_MINPER, acq_trig_pkg::OFF_DEBOUNCE, acq_trig_pkg::OFF_READOUT};
        logic [31:0] v [5] = '{acq_trig_pkg::RST_EXPOSE, acq_trig_pkg::RST_PERIOD,
            acq_trig_pkg::RST_MINPER, acq_trig_pkg::RST_DEBOUNCE, acq_trig_pkg::RST_READOUT};
        foreach (a[k]) begin
            rdr(a[k]);
            check(rd, v[k]);
        end
        rdr(8'h40);
        check({30'h0, rr}, {30'h0, acq_trig_pkg::RESP_SLVERR});
        check(rd, 32'h0000_0000);
        wr(8'h40, 32'h0000_0005);
        check({30'h0, rr}, {30'h0, acq_trig_pkg::RESP_SLVERR});
    endtask
    task automatic t_unarmed();
        wr(acq_trig_pkg::OFF_CFG, 32'h0000_0001);
        cmd(acq_trig_pkg::CMD_SWTRIG);
        idle(30);
        check(frames, 0);
        rdr(acq_trig_pkg::OFF_STATUS);
        check(rd, 32'h0000_0000);
    endtask
    task automatic t_sw();
        cmd(acq_trig_pkg::CMD_START);
        rdr(acq_trig_pkg::OFF_STATUS);
        check(rd, 32'h0000_0006);
        f0 = frames;
        cmd(acq_trig_pkg::CMD_SWTRIG);
        rdr(acq_trig_pkg::OFF_STATUS);
        check(rd[0], 1'b1);
        cmd(acq_trig_pkg::CMD_SWTRIG);
        cmd(acq_trig_pkg::CMD_START);
        idle(40);
        check(frames - f0, 1);
        check(last_w, EXPO);
        rdr(acq_trig_pkg::OFF_STATUS);
        check(rd, 32'h0000_0006);
    endtask
    task automatic t_stop();
        f0 = frames;
        cmd(acq_trig_pkg::CMD_SWTRIG);
        cmd(acq_trig_pkg::CMD_STOP);
        idle(40);
        check(frames - f0, 1);
        check(last_w, EXPO);
        rdr(acq_trig_pkg::OFF_STATUS);
        check(rd, 32'h0000_0000);
        cmd(acq_trig_pkg::CMD_SWTRIG);
        idle(30);
        check(frames - f0, 1);
        idle(RDOUT);
        cmd(acq_trig_pkg::CMD_START);
        cmd(acq_trig_pkg::CMD_STOP);
        rdr(acq_trig_pkg::OFF_STATUS);
        check(rd, 32'h0000_0000);
        idle(RDOUT);
        cmd(acq_trig_pkg::CMD_START);
    endtask
    task automatic fire(input logic [31:0] c, input int sel, input logic lvl, input int w);
        wr(acq_trig_pkg::OFF_CFG, c);
        i_grabber_model.rest(sel, ~lvl);
        idle(4);
        f0 = frames;
        i_grabber_model.pulse(sel, lvl, w);
        idle(40);
    endtask
    task automatic t_lines();
        fire(32'h0000_0023, 0, 1'b1, 20);
        check(frames - f0, 1);
        check(last_w, EXPO);
        fire(32'h0000_0043, 1, 1'b1, 20);
        check(frames - f0, 1);
        fire(32'h0000_0043, 1, 1'b1, 4);
        check(frames - f0, 0);
        fire(32'h0000_00B3, 2, 1'b1, 6);
        check(frames - f0, 1);
        fire(32'h0000_0025, 0, 1'b0, 15);
        check(last_w, 15);
        fire(32'h0000_0047, 1, 1'b1, 18);
        check(last_w, 18);
    endtask
    task automatic t_user();
        wr(acq_trig_pkg::OFF_CFG, 32'h0000_0013);
        f0 = frames;
        wr(acq_trig_pkg::OFF_CFG, 32'h0000_001B);
        idle(40);
        check(frames - f0, 1);
        wr(acq_trig_pkg::OFF_CFG, 32'h0000_0013);
        idle(40);
        check(frames - f0, 1);
    endtask
    task automatic t_free();
        wr(acq_trig_pkg::OFF_PERIOD, 32'h0000_001E);
        wr(acq_trig_pkg::OFF_MINPER, 32'h0000_0032);
        wr(acq_trig_pkg::OFF_CFG, 32'h0000_0000);
        idle(160);
        check(gap, 50);
        wr(acq_trig_pkg::OFF_PERIOD, 32'h0000_0046);
        idle(200);
        check(gap, 70);
        cmd(acq_trig_pkg::CMD_STOP);
    endtask
    initial begin
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        t_regs();
        wr(acq_trig_pkg::OFF_EXPOSE, EXPO);
        wr(acq_trig_pkg::OFF_READOUT, RDOUT);
        wr(acq_trig_pkg::OFF_MINPER, 32'h0000_0010);
        wr(acq_trig_pkg::OFF_DEBOUNCE, 32'h0000_0008);
        check({30'h0, rr}, {30'h0, acq_trig_pkg::RESP_OKAY});
        t_unarmed();
        t_sw();
        t_stop();
        t_lines();
        t_user();
        t_free();
        summarize();
    end
endmodule

// File: tb/grabber_model.sv
// far-side model: camera control, hardware trigger and timer lines
`timescale 1ns/100ps
module grabber_model (
    input wire logic clock_i, // core clock
    output logic cc_line_o, // camera control line one
    output logic hw_line_o, // hardware trigger line
    output logic timer_o // timer active output
);
    logic [2:0] lines = 3'h0;
    assign {timer_o, hw_line_o, cc_line_o} = lines;
    // level a line rests at between pulses
    task automatic rest(input int sel, input logic lvl);
        @(posedge clock_i);
        lines[sel] <= lvl;
    endtask
    // pulse at lvl for width cycles; callers space pulses beyond a frame time
    task automatic pulse(input int sel, input logic lvl, input int width);
        @(posedge clock_i);
        lines[sel] <= lvl;
        repeat (width) @(posedge clock_i);
        lines[sel] <= ~lvl;
    endtask
endmodule

// File: verilog/acq_trig_ctrl.sv
// acquisition arm/disarm, trigger select, exposure and strobe control
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
// Function
// - no frames acquired until the start command arms acquisition
// - stop while idle disarms immediately
// - stop during a frame lets it finish, then disarms
// - status flag reads true only while a frame is acquired
// - start command ignored while previous frame still in progress
// - continuous mode: each accepted trigger yields exactly one frame
// - accepted trigger leaves waiting; return to waiting when ready
// - trigger mode off: internal triggers at configured frame period
// - trigger mode on: one exposure per trigger from selected source
// - triggers outside the waiting state are discarded
// - five selectable sources: software, user bit, cc line, timer, hardware
// - each software trigger command makes exactly one trigger
// - user output bit edges act as rising and falling trigger edges
// - each camera control line pulse is an exposure trigger
// - timer source uses timer active output, fed by hardware input
// - each valid hardware input pulse is one trigger
// - timed exposure length comes from the exposure time register
// - trigger width mode exposes from active to opposite edge
// - hardware input debounced; only pulses this wide are valid
// - strobe output width follows each frame's exposure
// - activation setting picks rising or falling edge as start
// - requested frame period shorter than minimum is clamped to minimum
module acq_trig_ctrl #(
    parameter int CNT_W = 32
) (
    input wire logic clock_i, // core clock
    input wire logic rst_n_i, // synchronous reset, active low
    input wire acq_trig_pkg::axil_req_t axil_req_i, // register bus request
    output acq_trig_pkg::axil_rsp_t axil_rsp_o, // register bus answer
    input wire logic hw_trigger_input_i, // external trigger line
    input wire logic cc_line_i, // camera control line one
    input wire logic timer_active_signal_i, // timer active output
    output logic strobe_out_o, // strobe, high during exposure
    output logic frame_active_o // frame being acquired
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_EXPOSE, ST_READOUT} acq_state_t;

    acq_state_t state;
    logic armed;
    logic stop_pending;
    logic [31:0] cfg;
    logic [CNT_W-1:0] expose_time, frame_period, min_period, debounce_w, readout_time;
    logic [CNT_W-1:0] exp_cnt, rd_cnt, fr_cnt, db_cnt;
    logic hw_s1, hw_s2, hw_clean, hw_clean_d, cc_d, tmr_d, usr_d;
    logic strobe;

    // bus slave state
    logic aw_held, w_held, bvalid;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp, bresp;

    // bus decode
    wire aw_take = axil_req_i.awvalid && !aw_held && !bvalid;
    wire w_take = axil_req_i.wvalid && !w_held && !bvalid;
    wire [7:0] wr_addr = aw_held ? aw_addr : axil_req_i.awaddr;
    wire [31:0] wr_data = w_held ? w_data : axil_req_i.wdata;
    wire [3:0] wr_strb = w_held ? w_strb : axil_req_i.wstrb;
    wire wr_fire = (aw_held || aw_take) && (w_held || w_take);
    wire wr_cmd = wr_fire && wr_addr == acq_trig_pkg::OFF_CMD && wr_strb[0];
    wire wr_cfg = wr_fire && wr_addr == acq_trig_pkg::OFF_CFG;
    wire wr_exp = wr_fire && wr_addr == acq_trig_pkg::OFF_EXPOSE;
    wire wr_per = wr_fire && wr_addr == acq_trig_pkg::OFF_PERIOD;
    wire wr_min = wr_fire && wr_addr == acq_trig_pkg::OFF_MINPER;
    wire wr_db = wr_fire && wr_addr == acq_trig_pkg::OFF_DEBOUNCE;
    wire wr_rd = wr_fire && wr_addr == acq_trig_pkg::OFF_READOUT;
    wire wr_ok = wr_cmd || wr_cfg || wr_exp || wr_per || wr_min || wr_db || wr_rd
        || (wr_addr == acq_trig_pkg::OFF_CMD) || (wr_addr == acq_trig_pkg::OFF_STATUS);
    wire rd_take = axil_req_i.arvalid && !rvalid;

    wire cmd_start = wr_cmd && wr_data[acq_trig_pkg::CMD_START];
    wire cmd_stop = wr_cmd && wr_data[acq_trig_pkg::CMD_STOP];
    wire cmd_swtrig = wr_cmd && wr_data[acq_trig_pkg::CMD_SWTRIG];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // configuration decode
    wire trig_mode_on = cfg[acq_trig_pkg::CFG_TRIGMODE];
    wire act_rise = cfg[acq_trig_pkg::CFG_ACT_RISE];
    wire width_mode = cfg[acq_trig_pkg::CFG_WIDTH];
    wire user_output_bit = cfg[acq_trig_pkg::CFG_USEROUT];
    wire timer_hw_src = cfg[acq_trig_pkg::CFG_TMR_HW];
    wire [2:0] src = cfg[acq_trig_pkg::CFG_SRC_HI:acq_trig_pkg::CFG_SRC_LO];
    wire src_sw = src == 3'(acq_trig_pkg::SRC_SOFTWARE);
    wire src_usr = src == 3'(acq_trig_pkg::SRC_USER_OUT);
    wire src_cc = src == 3'(acq_trig_pkg::SRC_CC_LINE);
    wire src_tmr = src == 3'(acq_trig_pkg::SRC_TIMER);
    wire src_hw = src == 3'(acq_trig_pkg::SRC_HW_LINE);

    // hardware input conditioning
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            hw_s1 <= 1'b0;
            hw_s2 <= 1'b0;
        end else begin
            hw_s1 <= hw_trigger_input_i;
            hw_s2 <= hw_s1;
        end
    end

    // clean level changes only after the raw level held debounce_w cycles
    wire hw_differs = hw_s2 != hw_clean;
    wire db_done = db_cnt + CNT_W'(1) >= debounce_w;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            db_cnt <= '0;
            hw_clean <= 1'b0;
        end else if (!hw_differs) begin
            db_cnt <= '0;
        end else if (db_done) begin
            hw_clean <= hw_s2;
            db_cnt <= '0;
        end else begin
            db_cnt <= db_cnt + CNT_W'(1);
        end
    end

    // source selection and edges
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            hw_clean_d <= 1'b0;
            cc_d <= 1'b0;
            tmr_d <= 1'b0;
            usr_d <= 1'b0;
        end else begin
            hw_clean_d <= hw_clean;
            cc_d <= cc_line_i;
            tmr_d <= timer_active_signal_i;
            usr_d <= user_output_bit;
        end
    end

    // level of the selected line, and its delayed copy
    wire sel_lvl = (src_usr && user_output_bit) || (src_cc && cc_line_i)
        || (src_tmr && timer_hw_src && timer_active_signal_i)
        || (src_hw && hw_clean);
    wire sel_lvl_d = (src_usr && usr_d) || (src_cc && cc_d)
        || (src_tmr && timer_hw_src && tmr_d) || (src_hw && hw_clean_d);
    wire sel_rise = sel_lvl && !sel_lvl_d;
    wire sel_fall = !sel_lvl && sel_lvl_d;
    wire act_edge = act_rise ? sel_rise : sel_fall;
    wire end_edge = act_rise ? sel_fall : sel_rise;
    wire ext_trig = src_sw ? cmd_swtrig : act_edge;

    // free run period, clamped to the minimum the settings allow
    wire [CNT_W-1:0] eff_period = (frame_period < min_period) ? min_period : frame_period;
    wire free_trig = fr_cnt + CNT_W'(1) >= eff_period;
    wire trigger = trig_mode_on ? ext_trig : free_trig;
    wire accept = state == ST_WAIT && trigger && !cmd_stop;
    wire use_width = trig_mode_on && width_mode && !src_sw;
    wire exp_done = use_width ? end_edge : (exp_cnt + CNT_W'(1) >= expose_time);
    wire rd_done = rd_cnt + CNT_W'(1) >= readout_time;

    // period runs frame start to frame start; holds at its end until waiting
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !armed || trig_mode_on || accept) begin
            fr_cnt <= '0;
        end else if (!free_trig) begin
            fr_cnt <= fr_cnt + CNT_W'(1);
        end
    end

    // acquisition state machine
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            armed <= 1'b0;
            stop_pending <= 1'b0;
            exp_cnt <= '0;
            rd_cnt <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cmd_start) begin
                        state <= ST_WAIT;
                        armed <= 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (cmd_stop) begin
                        state <= ST_IDLE;
                        armed <= 1'b0;
                    end else if (accept) begin
                        state <= ST_EXPOSE;
                        exp_cnt <= '0;
                    end
                end
                ST_EXPOSE: begin
                    if (cmd_stop) begin
                        stop_pending <= 1'b1;
                    end
                    exp_cnt <= exp_cnt + CNT_W'(1);
                    if (exp_done) begin
                        state <= ST_READOUT;
                        rd_cnt <= '0;
                    end
                end
                ST_READOUT: begin
                    if (cmd_stop) begin
                        stop_pending <= 1'b1;
                    end
                    rd_cnt <= rd_cnt + CNT_W'(1);
                    if (rd_done) begin
                        if (stop_pending || cmd_stop) begin
                            state <= ST_IDLE;
                            armed <= 1'b0;
                            stop_pending <= 1'b0;
                        end else begin
                            state <= ST_WAIT;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
    // a start during a frame finds state not idle and is dropped

    wire in_frame = state == ST_EXPOSE || state == ST_READOUT;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            strobe <= 1'b0;
            frame_active_o <= 1'b0;
        end else begin
            strobe <= state == ST_EXPOSE && !exp_done || accept;
            frame_active_o <= (in_frame && !(state == ST_READOUT && rd_done)) || accept;
        end
    end
    assign strobe_out_o = strobe;

    // register write side
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cfg <= '0;
            expose_time <= CNT_W'(acq_trig_pkg::RST_EXPOSE);
            frame_period <= CNT_W'(acq_trig_pkg::RST_PERIOD);
            min_period <= CNT_W'(acq_trig_pkg::RST_MINPER);
            debounce_w <= CNT_W'(acq_trig_pkg::RST_DEBOUNCE);
            readout_time <= CNT_W'(acq_trig_pkg::RST_READOUT);
        end else begin
            if (wr_cfg) cfg <= merge(cfg, wr_data, wr_strb);
            if (wr_exp) expose_time <= CNT_W'(merge(32'(expose_time), wr_data, wr_strb));
            if (wr_per) frame_period <= CNT_W'(merge(32'(frame_period), wr_data, wr_strb));
            if (wr_min) min_period <= CNT_W'(merge(32'(min_period), wr_data, wr_strb));
            if (wr_db) debounce_w <= CNT_W'(merge(32'(debounce_w), wr_data, wr_strb));
            if (wr_rd) readout_time <= CNT_W'(merge(32'(readout_time), wr_data, wr_strb));
        end
    end

    // write channel handshake: address and data in either order
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b0;
            bresp <= acq_trig_pkg::RESP_OKAY;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_ok ? acq_trig_pkg::RESP_OKAY : acq_trig_pkg::RESP_SLVERR;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= axil_req_i.awaddr;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= axil_req_i.wdata;
                w_strb <= axil_req_i.wstrb;
            end
            if (bvalid && axil_req_i.bready) bvalid <= 1'b0;
        end
    end

    // register read side
    wire [31:0] status_word = {28'h0000000, strobe, state == ST_WAIT, armed, in_frame};
    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (axil_req_i.araddr)
            acq_trig_pkg::OFF_CMD: rd_mux = 32'h0000_0000;
            acq_trig_pkg::OFF_CFG: rd_mux = cfg;
            acq_trig_pkg::OFF_EXPOSE: rd_mux = 32'(expose_time);
            acq_trig_pkg::OFF_PERIOD: rd_mux = 32'(frame_period);
            acq_trig_pkg::OFF_MINPER: rd_mux = 32'(min_period);
            acq_trig_pkg::OFF_DEBOUNCE: rd_mux = 32'(debounce_w);
            acq_trig_pkg::OFF_STATUS: rd_mux = status_word;
            acq_trig_pkg::OFF_READOUT: rd_mux = 32'(readout_time);
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= acq_trig_pkg::RESP_OKAY;
        end else if (rd_take) begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_hit ? acq_trig_pkg::RESP_OKAY : acq_trig_pkg::RESP_SLVERR;
        end else if (rvalid && axil_req_i.rready) begin
            rvalid <= 1'b0;
        end
    end

    assign axil_rsp_o.awready = !aw_held && !bvalid;
    assign axil_rsp_o.wready = !w_held && !bvalid;
    assign axil_rsp_o.bvalid = bvalid;
    assign axil_rsp_o.bresp = bresp;
    assign axil_rsp_o.arready = !rvalid;
    assign axil_rsp_o.rvalid = rvalid;
    assign axil_rsp_o.rdata = rdata;
    assign axil_rsp_o.rresp = rresp;

    // assertions
    a_idle_no_frame: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !armed |-> state == ST_IDLE)
        else $error("frame state while disarmed");
    a_stop_idle_now: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state == ST_WAIT && cmd_stop) |=> (state == ST_IDLE && !armed))
        else $error("stop while waiting did not disarm");
    a_stop_finish_frame: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state == ST_EXPOSE && cmd_stop) |=> state != ST_IDLE)
        else $error("frame cut short by stop");
    a_start_ignored: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (in_frame && cmd_start && !cmd_stop && !rd_done) |=> in_frame)
        else $error("start disturbed running frame");
    a_status_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        accept |=> frame_active_o && status_word[acq_trig_pkg::STA_ACQ])
        else $error("status not set on frame start");
    a_trig_discard: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state == ST_READOUT && !rd_done) |=> state != ST_EXPOSE)
        else $error("trigger accepted outside waiting");
    a_trig_starts: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        accept |=> state == ST_EXPOSE && strobe_out_o)
        else $error("accepted trigger did not start exposure");
    a_strobe_expose: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $fell(strobe_out_o) |-> $past(exp_done))
        else $error("strobe ended without exposure end");
endmodule

// File: verilog/acq_trig_pkg.sv
// shared constants and types for the acquisition trigger controller
package acq_trig_pkg;
    localparam int CLK_MHZ = 100;
    // register byte offsets
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_EXPOSE = 8'h08;
    localparam logic [7:0] OFF_PERIOD = 8'h0C;
    localparam logic [7:0] OFF_MINPER = 8'h10;
    localparam logic [7:0] OFF_DEBOUNCE = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_READOUT = 8'h1C;
    // command bits (write one to execute)
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_SWTRIG = 2;
    // config fields
    localparam int CFG_TRIGMODE = 0;
    localparam int CFG_ACT_RISE = 1;
    localparam int CFG_WIDTH = 2;
    localparam int CFG_USEROUT = 3;
    localparam int CFG_SRC_LO = 4;
    localparam int CFG_SRC_HI = 6;
    localparam int CFG_TMR_HW = 7;
    // status fields
    localparam int STA_ACQ = 0;
    localparam int STA_ARMED = 1;
    localparam int STA_WAIT = 2;
    localparam int STA_STROBE = 3;
    // reset values, in clock cycles
    localparam logic [31:0] RST_EXPOSE = 32'h0000_03E8;
    localparam logic [31:0] RST_PERIOD = 32'h000F_4240;
    localparam logic [31:0] RST_MINPER = 32'h0000_2710;
    localparam logic [31:0] RST_DEBOUNCE = 32'h0000_0064;
    localparam logic [31:0] RST_READOUT = 32'h0000_1388;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SRC_SOFTWARE,
        SRC_USER_OUT,
        SRC_CC_LINE,
        SRC_TIMER,
        SRC_HW_LINE
    } trig_src_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;
endpackage
